//--- rtl/ssc_down_counter.sv
// Loadable down counter with a terminal flag
`timescale 1ns/1ps
`default_nettype none

module ssc_down_counter
#(
    parameter int WIDTH = 8
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Control
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    input wire logic enable,
    // Status
    output logic done
);

    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    always_comb
    begin
        next_count = count;
        if (load)
        begin
            next_count = load_value;
        end
        else if (enable && count != '0)
        begin
            next_count = count - WIDTH'(1);
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            count <= '0;
        end
        else
        begin
            count <= next_count;
        end
    end

    assign done = (count == '0);

endmodule // ssc_down_counter

`default_nettype wire

//--- rtl/ssc_pkg.sv
// Package of constants and types for the SRAM sleep mode control block
package ssc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLOCK_PERIOD_PS = 8000;
    localparam int SLEEP_RECOVERY_TIME_PS = 20000;
    // Least time: round up, never below one cycle
    localparam int RECOVERY_CYCLES_RAW =
        (SLEEP_RECOVERY_TIME_PS + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
    localparam int RECOVERY_CYCLES = (RECOVERY_CYCLES_RAW < 1) ? 1 : RECOVERY_CYCLES_RAW;
    localparam int ENTRY_DELAY_CYCLES = 2;
    localparam int COUNT_WIDTH = 8;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic RESET_ASLEEP = 1'b0;

    // ------------------------------------------------------------
    // Command encoding from the host
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        SSC_CMD_DESELECT = 2'h0,
        SSC_CMD_READ = 2'h1,
        SSC_CMD_WRITE = 2'h2
    } ssc_cmd_type;

    typedef enum logic [1:0]
    {
        SSC_AWAKE,
        SSC_ENTERING,
        SSC_ASLEEP,
        SSC_RECOVERING
    } ssc_state_type;

endpackage

//--- rtl/ssc_sleep_control.sv
// Sleep mode control for a synchronous burst SRAM
`timescale 1ns/1ps
`default_nettype none

module ssc_sleep_control
    import ssc_pkg::*;
#(
    parameter int RECOVERY_COUNT = ssc_pkg::RECOVERY_CYCLES,
    parameter int DATA_WIDTH = 36
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Sleep request from host
    input wire logic sleep_request,
    // Command from host
    input wire logic cmd_valid,
    input wire ssc_pkg::ssc_cmd_type cmd,
    input wire logic [DATA_WIDTH-1:0] read_data_in,
    // Gated command towards the memory core
    output logic core_cmd_valid,
    output ssc_pkg::ssc_cmd_type core_cmd,
    // Data output pins
    output logic [DATA_WIDTH-1:0] data_out,
    output logic data_out_enable_n,
    // Status
    output logic asleep,
    output logic recovering,
    output logic write_in_recovery
);

    import ssc_pkg::*;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    // True for a valid command of the given kind
    function automatic logic cmd_is(input logic valid, input ssc_cmd_type code,
        input ssc_cmd_type kind);
        return valid && (code == kind);
    endfunction

    // ------------------------------------------------------------
    // Sleep state machine
    // ------------------------------------------------------------
    ssc_state_type state;
    ssc_state_type next_state;
    // Cycles left before sleep takes hold
    logic [1:0] entry_count;
    logic [1:0] next_entry_count;
    logic recovery_load;
    logic recovery_done;

    // Loaded on the edge that leaves sleep, counted down once per recovering
    // cycle; recovery ends on the edge after it reaches zero
    ssc_down_counter
    #(
        .WIDTH(COUNT_WIDTH)
    )
    u_recovery
    (
        .clock(clock),
        .nrst(nrst),
        .load(recovery_load),
        .load_value(COUNT_WIDTH'(RECOVERY_COUNT)),
        .enable(state == SSC_RECOVERING),
        .done(recovery_done)
    );

    always_comb
    begin
        next_state = state;
        next_entry_count = entry_count;
        recovery_load = 1'b0;
        case (state)
            SSC_AWAKE:
            begin
                if (sleep_request)
                begin
                    next_state = SSC_ENTERING;
                    next_entry_count = 2'(ENTRY_DELAY_CYCLES - 1);
                end
            end
            SSC_ENTERING:
            begin
                // Request withdrawn before sleep took hold
                if (!sleep_request)
                begin
                    next_state = SSC_AWAKE;
                end
                else if (entry_count == 2'h0)
                begin
                    next_state = SSC_ASLEEP;
                end
                else
                begin
                    next_entry_count = entry_count - 2'h1;
                end
            end
            SSC_ASLEEP:
            begin
                if (!sleep_request)
                begin
                    next_state = SSC_RECOVERING;
                    recovery_load = 1'b1;
                end
            end
            SSC_RECOVERING:
            begin
                // A new request during recovery needs no second entry delay
                if (sleep_request)
                begin
                    next_state = SSC_ASLEEP;
                end
                else if (recovery_done)
                begin
                    next_state = SSC_AWAKE;
                end
            end
            default:
            begin
                next_state = SSC_AWAKE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= SSC_AWAKE;
            entry_count <= 2'h0;
        end
        else
        begin
            state <= next_state;
            entry_count <= next_entry_count;
        end
    end

    // ------------------------------------------------------------
    // Command gating and output drive
    // ------------------------------------------------------------
    logic next_core_cmd_valid;
    ssc_cmd_type next_core_cmd;
    logic [DATA_WIDTH-1:0] next_data_out;
    logic next_data_out_enable_n;
    logic next_asleep;
    logic next_recovering;
    logic next_write_in_recovery;
    logic sleeping;
    logic quiet;

    always_comb
    begin
        sleeping = (next_state == SSC_ASLEEP);
        // Commands sampled on the edge that leaves sleep are still ignored
        quiet = sleeping || (state == SSC_ASLEEP);
        next_asleep = sleeping;
        next_recovering = (next_state == SSC_RECOVERING);
        next_core_cmd_valid = cmd_valid;
        next_core_cmd = cmd;
        next_data_out = data_out;
        next_data_out_enable_n = 1'b1;
        next_write_in_recovery = 1'b0;
        if (quiet)
        begin
            next_core_cmd_valid = 1'b0;
            next_core_cmd = SSC_CMD_DESELECT;
            next_data_out = data_out;
            // A write lost to a request that returns in recovery is still flagged
            next_write_in_recovery = (state == SSC_RECOVERING)
                && cmd_is(cmd_valid, cmd, SSC_CMD_WRITE);
        end
        else if (state == SSC_RECOVERING && cmd_is(cmd_valid, cmd, SSC_CMD_WRITE))
        begin
            next_core_cmd_valid = 1'b0;
            next_core_cmd = SSC_CMD_DESELECT;
            next_write_in_recovery = 1'b1;
        end
        else if (cmd_is(cmd_valid, cmd, SSC_CMD_READ))
        begin
            next_data_out = read_data_in;
            next_data_out_enable_n = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            core_cmd_valid <= 1'b0;
            core_cmd <= SSC_CMD_DESELECT;
            data_out <= '0;
            data_out_enable_n <= 1'b1;
            asleep <= RESET_ASLEEP;
            recovering <= 1'b0;
            write_in_recovery <= 1'b0;
        end
        else
        begin
            core_cmd_valid <= next_core_cmd_valid;
            core_cmd <= next_core_cmd;
            data_out <= next_data_out;
            data_out_enable_n <= next_data_out_enable_n;
            asleep <= next_asleep;
            recovering <= next_recovering;
            write_in_recovery <= next_write_in_recovery;
        end
    end

endmodule // ssc_sleep_control

`default_nettype wire

//--- tb/ssc_host_model.sv
// Host controller model
`timescale 1ns/1ps
`default_nettype none
module ssc_host_model
    import ssc_pkg::*;
(
    // Clock
    input wire logic clock,
    input wire logic nrst,
    // Bench requests
    input wire logic want_sleep,
    input wire logic want_op,
    input wire ssc_pkg::ssc_cmd_type op,
    input wire logic bad_write,
    input wire logic recovering,
    // Pins
    output logic sleep_request,
    output logic cmd_valid,
    output ssc_pkg::ssc_cmd_type cmd
);
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            sleep_request <= 1'b0;
            cmd_valid <= 1'b0;
            cmd <= SSC_CMD_DESELECT;
        end
        else
        begin
            sleep_request <= want_sleep && (sleep_request || !cmd_valid);
            cmd_valid <= want_op;
            cmd <= (op == SSC_CMD_WRITE && recovering && !bad_write) ? SSC_CMD_DESELECT : op;
        end
    end
endmodule // ssc_host_model
`default_nettype wire

//--- tb/ssc_sleep_monitor.sv
// Sleep control checker
`timescale 1ns/1ps
`default_nettype none
module ssc_sleep_monitor
    import ssc_pkg::*;
#(parameter int RECOVERY_COUNT = 3)
(
    // Clock
    input wire logic clock,
    input wire logic nrst,
    // Host side
    input wire logic sleep_request,
    input wire logic cmd_valid,
    input wire ssc_pkg::ssc_cmd_type cmd,
    // Outputs
    input wire ssc_pkg::ssc_cmd_type core_cmd,
    input wire logic data_out_enable_n,
    input wire logic asleep,
    input wire logic recovering,
    input wire logic write_in_recovery
);
    // Length of the current recovery interval
    int run;
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            run <= 0;
        else
            run <= recovering ? run + 1 : 0;
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    property p_entry;
        !asleep && !recovering && $rose(sleep_request) ##1 sleep_request[*2]
            |-> !asleep ##1 asleep;
    endproperty
    a_entry: assert property (p_entry) else $error("sleep entry timing");
    property p_stay; asleep && sleep_request |=> asleep; endproperty
    a_stay: assert property (p_stay) else $error("left sleep early");
    property p_exit; asleep && !sleep_request |=> !asleep && recovering; endproperty
    a_exit: assert property (p_exit) else $error("no recovery on exit");
    property p_quiet;
        asleep |=> data_out_enable_n && core_cmd == SSC_CMD_DESELECT;
    endproperty
    a_quiet: assert property (p_quiet) else $error("active while asleep");
    property p_rmin; $fell(recovering) && !asleep |-> run >= RECOVERY_COUNT; endproperty
    a_rmin: assert property (p_rmin) else $error("recovery too short");
    property p_rmax; $rose(recovering) |-> ##[1:8] !recovering; endproperty
    a_rmax: assert property (p_rmax) else $error("recovery too long");
    property p_wdrop;
        recovering && cmd_valid && cmd == SSC_CMD_WRITE
            |=> write_in_recovery && core_cmd == SSC_CMD_DESELECT;
    endproperty
    a_wdrop: assert property (p_wdrop) else $error("write in recovery passed");
    property p_read;
        !asleep && cmd_valid && cmd == SSC_CMD_READ
            |=> core_cmd == SSC_CMD_READ && !data_out_enable_n;
    endproperty
    a_read: assert property (p_read) else $error("read not served");
endmodule // ssc_sleep_monitor
bind ssc_sleep_control ssc_sleep_monitor #(.RECOVERY_COUNT(RECOVERY_COUNT)) mon (
    .clock(clock), .nrst(nrst), .sleep_request(sleep_request), .cmd_valid(cmd_valid),
    .cmd(cmd), .core_cmd(core_cmd), .data_out_enable_n(data_out_enable_n),
    .asleep(asleep), .recovering(recovering), .write_in_recovery(write_in_recovery));
`default_nettype wire

//--- tb/tb_sram_sleep_mode_control.sv
// Bench for the sleep control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin err_count++; \
    $display("unexpected %s: expected %0h seen %0h", nm, ex, got); end end
module tb_sram_sleep_mode_control;
    import ssc_pkg::*;
    localparam logic [35:0] RD = 36'h9_A5C3_0F1E;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic want_sleep = 1'b0;
    logic want_op = 1'b0;
    logic bad_write = 1'b0;
    ssc_cmd_type op = SSC_CMD_DESELECT;
    logic [35:0] read_data_in = RD;
    logic sleep_request, cmd_valid, core_cmd_valid, data_out_enable_n;
    logic asleep, recovering, write_in_recovery;
    logic [35:0] data_out;
    ssc_cmd_type cmd, core_cmd;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;
    always #4 clock = ~clock;
    ssc_host_model host (.clock(clock), .nrst(nrst), .want_sleep(want_sleep),
        .want_op(want_op), .op(op), .bad_write(bad_write), .recovering(recovering),
        .sleep_request(sleep_request), .cmd_valid(cmd_valid), .cmd(cmd));
    ssc_sleep_control #(.RECOVERY_COUNT(RECOVERY_CYCLES)) uut (.clock(clock), .nrst(nrst),
        .sleep_request(sleep_request), .cmd_valid(cmd_valid), .cmd(cmd),
        .read_data_in(read_data_in), .core_cmd_valid(core_cmd_valid), .core_cmd(core_cmd),
        .data_out(data_out), .data_out_enable_n(data_out_enable_n), .asleep(asleep),
        .recovering(recovering), .write_in_recovery(write_in_recovery));
    // One command; the design answers two edges after the request
    task automatic issue(input ssc_cmd_type c);
        @(posedge clock);
        want_op <= 1'b1;
        op <= c;
        @(posedge clock);
        want_op <= 1'b0;
        @(posedge clock);
        #1;
    endtask
    task automatic t_read;
        issue(SSC_CMD_READ);
        `CHK("read cmd", SSC_CMD_READ, core_cmd)
        `CHK("read data", RD, data_out)
        `CHK("read valid", 1'b1, core_cmd_valid)
        `CHK("read oe_n", 1'b0, data_out_enable_n)
    endtask
    task automatic t_sleep;
        @(posedge clock);
        want_sleep <= 1'b1;
        read_data_in <= ~RD;
        // Host raises the pin one edge later; sleep shows three edges after that
        repeat (3) @(posedge clock);
        #1;
        `CHK("asleep early", 1'b0, asleep)
        @(posedge clock);
        #1;
        `CHK("asleep", 1'b1, asleep)
        issue(SSC_CMD_READ);
        `CHK("sleep oe_n", 1'b1, data_out_enable_n)
        `CHK("sleep cmd", SSC_CMD_DESELECT, core_cmd)
        `CHK("sleep valid", 1'b0, core_cmd_valid)
        repeat (20) @(posedge clock);
        #1;
        `CHK("asleep held", 1'b1, asleep)
        `CHK("data kept", RD, data_out)
        // Wake, then a write and a read back to back inside recovery
        @(posedge clock);
        want_sleep <= 1'b0;
        bad_write <= 1'b1;
        read_data_in <= RD;
        @(posedge clock);
        want_op <= 1'b1;
        op <= SSC_CMD_WRITE;
        @(posedge clock);
        op <= SSC_CMD_READ;
        #1;
        `CHK("recovering", 1'b1, recovering)
        `CHK("awake on exit", 1'b0, asleep)
        @(posedge clock);
        want_op <= 1'b0;
        #1;
        `CHK("write flag", 1'b1, write_in_recovery)
        `CHK("write gated", SSC_CMD_DESELECT, core_cmd)
        @(posedge clock);
        bad_write <= 1'b0;
        #1;
        `CHK("recovery read", RD, data_out)
        n = 3;
        while (recovering === 1'b1 && n < 10)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        `CHK("recovery span", 1'b1, n > RECOVERY_CYCLES && n < 10)
        issue(SSC_CMD_WRITE);
        `CHK("write after", SSC_CMD_WRITE, core_cmd)
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 500)
        begin
            err_count++;
            wrap_up();
        end
    end
    initial
    begin
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        t_read();
        t_sleep();
        t_read();
        wrap_up();
    end
endmodule // tb_sram_sleep_mode_control
`default_nettype wire
